// [logic/ets_pkg.sv]
// constants and types for the exercise and transfer sequencer
package ets_pkg;
   // register byte offsets
   localparam logic [7:0] ETS_CTRL_OFS = 8'h00;
   localparam logic [7:0] ETS_SCHED_OFS = 8'h04;
   localparam logic [7:0] ETS_TDLY_OFS = 8'h08;
   localparam logic [7:0] ETS_SUPV_OFS = 8'h0C;
   localparam logic [7:0] ETS_CLOCK_OFS = 8'h10;
   localparam logic [7:0] ETS_STAT_OFS = 8'h14;
   localparam logic [7:0] ETS_CLR_OFS = 8'h18;
   // ctrl field positions
   localparam int ETS_C_AUTO = 0;
   localparam int ETS_C_SCHED_EN = 1;
   localparam int ETS_C_MAINS_EN = 2;
   localparam int ETS_C_FB_EN = 3;
   localparam int ETS_C_SLEEP_REQ = 4;
   localparam int ETS_C_DST_EN = 5;
   // schedule field positions
   localparam int ETS_S_MIN = 0;
   localparam int ETS_S_HOUR = 8;
   localparam int ETS_S_DAY = 12;
   localparam int ETS_S_PM = 15;
   localparam int ETS_S_INTV = 16;
   localparam int ETS_S_DUR = 20;
   // reset values
   localparam logic [31:0] ETS_SCHED_RST = 32'h00F0_0C00;
   localparam logic [31:0] ETS_TDLY_RST = 32'h0005_0005;
   localparam logic [31:0] ETS_SUPV_RST = 32'h0005_0005;
   localparam logic [31:0] ETS_CLOCK_RST = 32'h0000_0000;
   // durations and display cadence
   localparam int ETS_DUR_MIN = 5;
   localparam int ETS_DUR_MAX = 15;
   localparam int ETS_CLK_HZ = 250_000_000;
   localparam int ETS_SHOW_SEC = 1;
   localparam int ETS_TOGGLE_SEC = 3;
   localparam logic [1:0] ETS_RESP_OKAY = 2'b00;
   localparam logic [1:0] ETS_RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      ETS_IV_WEEKLY, ETS_IV_BIMONTHLY, ETS_IV_MONTHLY, ETS_IV_QUARTERLY, ETS_IV_SEMIANNUAL
   } ets_intv_t;
   typedef enum {
      ETS_IDLE, ETS_START_DLY, ETS_RUN_WAIT, ETS_XFER_DLY, ETS_XFER_SUPV, ETS_ON_LOAD,
      ETS_RETX_DLY, ETS_RETX_SUPV, ETS_STOP_DLY
   } ets_state_t;
endpackage : ets_pkg

// [logic/ets_sequencer.sv]
// exercise scheduler and transfer-switch sequencer with axi4-lite registers
//
// Operation
// - exercise launches only in auto, clock set, program enabled
// - enabled scheduler blocks entry into sleep
// - one repeating program, no exceptions, rated speed with no load
// - start time: minute 0-59, hour 1-12, weekday, am/pm
// - repeat weekly, twice monthly, monthly, quarterly or semi-annually
// - run lasts 5 to 15 minutes, counted per run
// - exercise issues engine start at rated, load stays off
// - exercise indication shown 1 s out of every 3 s
// - clock/schedule writes refused while exercising, ctrl (enables, dst) excepted; flag raised
// - remote start ends exercise, zeroes timer, runs until remote start drops
// - transfer sequencing needs mains transfer enable and auto mode
// - transfer plus feedback enabled locks inputs 1 and 2 to feedback
// - input 1 is utility side, input 2 generator side
// - remote start: engine start after start delay, transfer delay on running
// - ready, enabled and delay done: assert transfer output
// - supervise utility-open/generator-closed; timeout is shutdown fault
// - remote start release starts re-transfer delay before output drops
// - supervise generator-open/utility-closed; timeout is warning
// - stop delay only after re-transfer confirmed, then engine stop
// - invalid feedback pair raises position-unknown warning
// - feedback disabled: sequence from output state alone, no supervision
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module ets_sequencer import ets_pkg::*; #(
   parameter int TICKS_PER_SEC = ETS_CLK_HZ
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // calendar and engine
   input wire logic [5:0] cal_minute,
   input wire logic [3:0] cal_hour,
   input wire logic [2:0] cal_weekday,
   input wire logic cal_pm,
   input wire logic [4:0] cal_mday,
   input wire logic [3:0] cal_month,
   input wire logic clock_not_set_fault,
   input wire logic engine_running,
   input wire logic engine_ready_to_load,
   // transfer switch
   input wire logic remote_start,
   input wire logic cfg_input1,
   input wire logic cfg_input2,
   // outputs
   output logic engine_start_cmd,
   output logic rated_no_load,
   output logic load_transfer_output,
   output logic exercise_active,
   output logic exercise_display,
   output logic sleep_allowed,
   output logic cfg_inputs_locked,
   output logic gen_fail_close_fault,
   output logic util_fail_close_warn,
   output logic switch_unknown_warn
);
   initial begin
      if (TICKS_PER_SEC < 4) $error("TICKS_PER_SEC too small");
   end

   localparam int SEC_W = $clog2(TICKS_PER_SEC);
   localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(TICKS_PER_SEC - 1);
   localparam logic [1:0] DISP_LAST = 2'(ETS_TOGGLE_SEC - 1);
   localparam logic [1:0] DISP_ON = 2'(ETS_SHOW_SEC);

   // registers
   logic [5:0] ctrl_reg, ctrl_next;
   logic [31:0] sched_reg, sched_next, tdly_reg, tdly_next, supv_reg, supv_next, clock_reg, clock_next;
   logic refused_reg, refused_next;
   // axi state
   logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
   logic [7:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [3:0] ws_reg, ws_next;
   logic [1:0] br_reg, br_next, rr_reg, rr_next;
   // sequencer
   ets_state_t st_reg, st_next;
   logic [SEC_W-1:0] tick_reg, tick_next;
   logic [15:0] tmr_reg, tmr_next;
   logic exer_reg, exer_next;
   logic [3:0] dur_reg, dur_next;
   logic [5:0] exsec_reg, exsec_next;
   logic [1:0] disp_reg, disp_next;
   logic fired_reg, fired_next;
   logic [3:0] mcnt_reg, mcnt_next;
   logic [1:0] oq_reg, oq_next;
   logic start_reg, start_next, xfer_reg, xfer_next, rnl_reg, rnl_next, sleep_reg, sleep_next;
   logic lock_reg, lock_next, gfc_reg, gfc_next, ufc_reg, ufc_next, unk_reg, unk_next, show_reg, show_next;

   logic sec_pulse, launch, seq_en, fb_en, match, due, util_closed, gen_closed;
   logic [3:0] dur_cfg;
   logic [31:0] wmask, rdata;

   // one-second time base; seconds are counted in exsec_reg and minutes in dur_reg during exercise
   always_comb begin
      sec_pulse = (tick_reg == SEC_LAST);
      // restart the second at launch so the first display second is whole
      tick_next = (sec_pulse || launch) ? '0 : tick_reg + 1'b1;
   end

   // axi4-lite slave and register file
   always_comb begin
      wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
      aw_next = aw_reg;
      w_next = w_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      rv_next = rv_reg;
      rr_next = rr_reg;
      rd_next = rd_reg;
      ctrl_next = ctrl_reg;
      sched_next = sched_reg;
      tdly_next = tdly_reg;
      supv_next = supv_reg;
      clock_next = clock_reg;
      refused_next = refused_reg;
      if (s_axi_awvalid && !aw_reg && !bv_reg) begin
         aw_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_reg && !bv_reg) begin
         w_next = 1'b1;
         wd_next = s_axi_wdata;
         ws_next = s_axi_wstrb;
      end
      if (aw_reg && w_reg) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         br_next = ETS_RESP_OKAY;
         case (awa_reg)
            ETS_CTRL_OFS: ctrl_next = 6'((ctrl_reg & ~wmask[5:0]) | (wd_reg[5:0] & wmask[5:0]));
            ETS_SCHED_OFS, ETS_CLOCK_OFS: begin
               if (exer_reg) begin
                  refused_next = 1'b1;
                  br_next = ETS_RESP_SLVERR;
               end else if (awa_reg == ETS_SCHED_OFS) begin
                  sched_next = (sched_reg & ~wmask) | (wd_reg & wmask);
               end else begin
                  clock_next = (clock_reg & ~wmask) | (wd_reg & wmask);
               end
            end
            ETS_TDLY_OFS: tdly_next = (tdly_reg & ~wmask) | (wd_reg & wmask);
            ETS_SUPV_OFS: supv_next = (supv_reg & ~wmask) | (wd_reg & wmask);
            ETS_CLR_OFS: if (wd_reg[0] && wmask[0]) refused_next = 1'b0;
            ETS_STAT_OFS: br_next = ETS_RESP_OKAY;
            default: br_next = ETS_RESP_SLVERR;
         endcase
      end
      if (bv_reg && s_axi_bready) bv_next = 1'b0;
      case (s_axi_araddr)
         ETS_CTRL_OFS: rdata = {26'h0, ctrl_reg};
         ETS_SCHED_OFS: rdata = sched_reg;
         ETS_TDLY_OFS: rdata = tdly_reg;
         ETS_SUPV_OFS: rdata = supv_reg;
         ETS_CLOCK_OFS: rdata = clock_reg;
         ETS_STAT_OFS: rdata = {16'h0, 4'(st_reg), dur_reg, unk_reg, ufc_reg, gfc_reg, refused_reg,
                                xfer_reg, start_reg, lock_reg, exer_reg};
         default: rdata = 32'h0000_0000;
      endcase
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rd_next = rdata;
         rr_next = (s_axi_araddr inside {ETS_CTRL_OFS, ETS_SCHED_OFS, ETS_TDLY_OFS, ETS_SUPV_OFS,
                    ETS_CLOCK_OFS, ETS_STAT_OFS}) ? ETS_RESP_OKAY : ETS_RESP_SLVERR;
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   // exercise scheduler and transfer sequencing
   always_comb begin
      seq_en = ctrl_reg[ETS_C_MAINS_EN] && ctrl_reg[ETS_C_AUTO];
      fb_en = seq_en && ctrl_reg[ETS_C_FB_EN];
      util_closed = cfg_input1 && !cfg_input2;
      gen_closed = !cfg_input1 && cfg_input2;
      dur_cfg = sched_reg[ETS_S_DUR +: 4];
      if (dur_cfg < 4'(ETS_DUR_MIN)) dur_cfg = 4'(ETS_DUR_MIN);
      if (dur_cfg > 4'(ETS_DUR_MAX)) dur_cfg = 4'(ETS_DUR_MAX);
      match = (cal_minute == sched_reg[ETS_S_MIN +: 6]) && (cal_hour == sched_reg[ETS_S_HOUR +: 4]) &&
              (cal_weekday == sched_reg[ETS_S_DAY +: 3]) && (cal_pm == sched_reg[ETS_S_PM]);
      // repeat interval gates which weekday matches run; counts months since last run
      case (ets_intv_t'(sched_reg[ETS_S_INTV +: 3]))
         ETS_IV_WEEKLY: due = 1'b1;
         ETS_IV_BIMONTHLY: due = (cal_mday <= 5'd7) || (cal_mday >= 5'd15 && cal_mday <= 5'd21);
         ETS_IV_MONTHLY: due = (cal_mday <= 5'd7);
         ETS_IV_QUARTERLY: due = (cal_mday <= 5'd7) && (mcnt_reg >= 4'd3);
         ETS_IV_SEMIANNUAL: due = (cal_mday <= 5'd7) && (mcnt_reg >= 4'd6);
         default: due = 1'b0;
      endcase
      st_next = st_reg;
      tmr_next = (tmr_reg != 16'h0000 && sec_pulse) ? tmr_reg - 16'h0001 : tmr_reg;
      exer_next = exer_reg;
      dur_next = dur_reg;
      exsec_next = exsec_reg;
      fired_next = match ? fired_reg : 1'b0;
      oq_next = oq_reg;
      mcnt_next = mcnt_reg;
      if (oq_reg != cal_month[1:0] && mcnt_reg != 4'hF) mcnt_next = mcnt_reg + 4'd1;
      oq_next = cal_month[1:0];
      gfc_next = gfc_reg;
      ufc_next = ufc_reg;
      // one program only: launch once per calendar minute match
      launch = !exer_reg && match && due && !fired_reg && ctrl_reg[ETS_C_AUTO] && !clock_not_set_fault &&
               ctrl_reg[ETS_C_SCHED_EN] && !remote_start;
      if (launch) begin
         exer_next = 1'b1;
         fired_next = 1'b1;
         dur_next = 4'h0;
         exsec_next = 6'd0;
         mcnt_next = 4'h0;
      end else if (exer_reg) begin
         if (sec_pulse) exsec_next = (exsec_reg == 6'd59) ? 6'd0 : exsec_reg + 6'd1;
         if (sec_pulse && exsec_reg == 6'd59) dur_next = dur_reg + 4'd1;
         if (remote_start || !ctrl_reg[ETS_C_AUTO] || !ctrl_reg[ETS_C_SCHED_EN]) begin
            exer_next = 1'b0;
            dur_next = 4'h0;
         end else if (dur_reg >= dur_cfg) begin
            exer_next = 1'b0;
            dur_next = 4'h0;
         end
      end
      disp_next = (exer_reg && sec_pulse) ? ((disp_reg == DISP_LAST) ? 2'd0 : disp_reg + 2'd1) :
                  (exer_reg ? disp_reg : 2'd0);
      case (st_reg)
         ETS_IDLE: if (remote_start && ctrl_reg[ETS_C_AUTO]) begin
            st_next = ETS_START_DLY;
            tmr_next = {8'h00, tdly_reg[31:24]};
         end
         ETS_START_DLY: if (!remote_start) st_next = ETS_IDLE;
            else if (tmr_reg == 16'h0000) st_next = ETS_RUN_WAIT;
         ETS_RUN_WAIT: if (!remote_start) begin
            st_next = ETS_STOP_DLY;
            tmr_next = {8'h00, tdly_reg[23:16]};
         end else if (engine_running && seq_en) begin
            st_next = ETS_XFER_DLY;
            tmr_next = {8'h00, tdly_reg[7:0]};
         end
         ETS_XFER_DLY: if (!remote_start) begin
            st_next = ETS_STOP_DLY;
            tmr_next = {8'h00, tdly_reg[23:16]};
         end else if (tmr_reg == 16'h0000 && engine_ready_to_load && seq_en) begin
            st_next = fb_en ? ETS_XFER_SUPV : ETS_ON_LOAD;
            tmr_next = supv_reg[15:0];
         end
         ETS_XFER_SUPV: if (gen_closed) st_next = ETS_ON_LOAD;
            else if (tmr_reg == 16'h0000) begin
               gfc_next = 1'b1;
               st_next = ETS_IDLE;
            end
         ETS_ON_LOAD: if (!remote_start) begin
            st_next = ETS_RETX_DLY;
            tmr_next = {8'h00, tdly_reg[15:8]};
         end
         ETS_RETX_DLY: if (remote_start) st_next = ETS_ON_LOAD;
            else if (tmr_reg == 16'h0000) begin
               st_next = fb_en ? ETS_RETX_SUPV : ETS_STOP_DLY;
               tmr_next = fb_en ? supv_reg[31:16] : {8'h00, tdly_reg[23:16]};
            end
         ETS_RETX_SUPV: if (util_closed) begin
            st_next = ETS_STOP_DLY;
            tmr_next = {8'h00, tdly_reg[23:16]};
         end else if (tmr_reg == 16'h0000 && !ufc_reg) begin
            ufc_next = 1'b1;
         end
         ETS_STOP_DLY: if (remote_start) st_next = ETS_START_DLY;
            else if (tmr_reg == 16'h0000) st_next = ETS_IDLE;
         default: st_next = ETS_IDLE;
      endcase
      // faults latch until mains transfer or auto mode is disabled
      if (!seq_en) begin
         gfc_next = 1'b0;
         ufc_next = 1'b0;
      end
      start_next = exer_next || !(st_next inside {ETS_IDLE, ETS_START_DLY}) ||
                   (st_next == ETS_START_DLY && start_reg);
      rnl_next = exer_next;
      show_next = exer_next && (disp_next < DISP_ON);
      xfer_next = (st_next inside {ETS_ON_LOAD, ETS_XFER_SUPV, ETS_RETX_DLY}) && seq_en;
      sleep_next = ctrl_reg[ETS_C_SLEEP_REQ] && !ctrl_reg[ETS_C_SCHED_EN];
      lock_next = fb_en;
      unk_next = fb_en && (cfg_input1 == cfg_input2);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_reg, w_reg, bv_reg, rv_reg, refused_reg, exer_reg, fired_reg} <= 7'h00;
         {br_reg, rr_reg} <= {ETS_RESP_OKAY, ETS_RESP_OKAY};
         {awa_reg, ws_reg, ctrl_reg, disp_reg, oq_reg} <= 22'h0;
         {wd_reg, rd_reg} <= 64'h0;
         sched_reg <= ETS_SCHED_RST;
         tdly_reg <= ETS_TDLY_RST;
         supv_reg <= ETS_SUPV_RST;
         clock_reg <= ETS_CLOCK_RST;
         tick_reg <= '0;
         st_reg <= ETS_IDLE;
         {tmr_reg, dur_reg, exsec_reg} <= 26'h0;
         mcnt_reg <= 4'hF;
         {start_reg, xfer_reg, rnl_reg, sleep_reg, lock_reg, gfc_reg, ufc_reg, unk_reg, show_reg} <= 9'h000;
      end else begin
         {aw_reg, w_reg, bv_reg, rv_reg, refused_reg, exer_reg, fired_reg} <=
            {aw_next, w_next, bv_next, rv_next, refused_next, exer_next, fired_next};
         {br_reg, rr_reg, awa_reg, ws_reg, ctrl_reg, disp_reg, oq_reg} <=
            {br_next, rr_next, awa_next, ws_next, ctrl_next, disp_next, oq_next};
         {wd_reg, rd_reg, sched_reg, tdly_reg, supv_reg, clock_reg} <=
            {wd_next, rd_next, sched_next, tdly_next, supv_next, clock_next};
         {tick_reg, tmr_reg, dur_reg, exsec_reg, mcnt_reg} <= {tick_next, tmr_next, dur_next, exsec_next, mcnt_next};
         st_reg <= st_next;
         {start_reg, xfer_reg, rnl_reg, sleep_reg, lock_reg, gfc_reg, ufc_reg, unk_reg, show_reg} <=
            {start_next, xfer_next, rnl_next, sleep_next, lock_next, gfc_next, ufc_next, unk_next, show_next};
      end
   end

   assign s_axi_awready = !aw_reg && !bv_reg;
   assign s_axi_wready = !w_reg && !bv_reg;
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp = br_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata = rd_reg;
   assign s_axi_rresp = rr_reg;
   assign engine_start_cmd = start_reg;
   assign rated_no_load = rnl_reg;
   assign load_transfer_output = xfer_reg;
   assign exercise_active = exer_reg;
   assign exercise_display = show_reg;
   assign sleep_allowed = sleep_reg;
   assign cfg_inputs_locked = lock_reg;
   assign gen_fail_close_fault = gfc_reg;
   assign util_fail_close_warn = ufc_reg;
   assign switch_unknown_warn = unk_reg;
endmodule : ets_sequencer

// [tb/ets_sequencer_assertions.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
module ets_sequencer_chk (
   // clock, reset, bus
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // engine and switch
   input wire logic engine_ready_to_load,
   input wire logic cfg_input1,
   input wire logic cfg_input2,
   // outputs
   input wire logic engine_start_cmd,
   input wire logic rated_no_load,
   input wire logic load_transfer_output,
   input wire logic exercise_active,
   input wire logic exercise_display,
   input wire logic sleep_allowed,
   input wire logic gen_fail_close_fault,
   input wire logic util_fail_close_warn,
   input wire logic switch_unknown_warn
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_xfer_ready: assert property ($rose(load_transfer_output) |-> $past(engine_ready_to_load))
      else $error("transfer before ready");
   a_exer_run: assert property (exercise_active && $past(exercise_active) |-> engine_start_cmd && rated_no_load)
      else $error("no rated run");
   a_exer_noload: assert property (exercise_active |-> !load_transfer_output)
      else $error("load in exercise");
   a_sleep_block: assert property (exercise_active |-> !sleep_allowed)
      else $error("sleep in exercise");
   a_disp_idle: assert property (!exercise_active && !$past(exercise_active) |-> !exercise_display)
      else $error("stray display");
   a_disp_hold: assert property ($rose(exercise_display) |=> (exercise_display || !exercise_active) [*8])
      else $error("display pulse too short");
   a_gfc_cause: assert property ($rose(gen_fail_close_fault) |-> $past(load_transfer_output) && !cfg_input2)
      else $error("stray close fault");
   a_ufc_cause: assert property ($rose(util_fail_close_warn) |-> !$past(load_transfer_output) && !cfg_input1)
      else $error("stray return warning");
   a_unk_cause: assert property (switch_unknown_warn |-> $past(cfg_input1 == cfg_input2))
      else $error("stray unknown warning");
   a_stop_confirm: assert property ($fell(engine_start_cmd) && !gen_fail_close_fault |-> cfg_input1)
      else $error("early stop");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   c_exer: cover property ($rose(exercise_active));
   c_xfer: cover property ($rose(load_transfer_output));
   c_gfc: cover property ($rose(gen_fail_close_fault));
endmodule : ets_sequencer_chk

// [tb/ets_switch_model.sv]
// transfer switch and mains sensing relay model
`timescale 1ns/100ps
module ets_switch_model #(
   parameter logic [7:0] DROP = 8'h60,
   parameter logic [7:0] PICK = 8'hA0,
   parameter int TRAVEL = 6
) (
   // sensing and command
   input wire logic aclk,
   input wire logic [7:0] volts,
   input wire logic load_transfer_output,
   // 0 normal, 1 stuck, 2 both contacts open
   input wire logic [1:0] mode,
   // to the controller
   output logic remote_start,
   output logic cfg_input1,
   output logic cfg_input2
);
   logic on_gen = 1'h0;
   int cnt = 0;
   initial remote_start = 1'h0;
   // hysteresis band stops the start line chattering
   always @(posedge aclk) begin
      if (volts < DROP) remote_start <= 1'h1;
      else if (volts > PICK) remote_start <= 1'h0;
      if (mode == 2'h1 || on_gen == load_transfer_output) cnt <= 0;
      else if (cnt == TRAVEL) begin
         on_gen <= load_transfer_output;
         cnt <= 0;
      end else cnt <= cnt + 1;
   end
   // old contact opens halfway through travel, so both read open briefly
   assign cfg_input1 = mode != 2'h2 && !on_gen && cnt < TRAVEL / 2;
   assign cfg_input2 = mode != 2'h2 && on_gen && cnt < TRAVEL / 2;
endmodule : ets_switch_model

// [tb/test_exercise_and_transfer_sequencer.sv]
// self-checking bench for the sequencer
`timescale 1ns/100ps
module test_exercise_and_transfer_sequencer import ets_pkg::*;;
   localparam int TPS = 10;
   localparam int MINC = 60 * TPS;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ets_exp_t;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, volts = 8'hC8, st, sp, rt, tx;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h6E26;
   logic [3:0] s_axi_wstrb = 4'hF, cal_hour = 4'h8, cal_month = 4'h1, dur;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, mode = 2'h0;
   logic [5:0] cal_minute = 6'h14;
   logic [2:0] cal_weekday = 3'h1, iv = 3'h0;
   logic [4:0] cal_mday = 5'h01;
   logic cal_pm = 1'h0, clock_not_set_fault = 1'h1, engine_running = 1'h0, engine_ready_to_load = 1'h0;
   logic remote_start, cfg_input1, cfg_input2, engine_start_cmd, rated_no_load, load_transfer_output;
   logic exercise_active, exercise_display, sleep_allowed, cfg_inputs_locked;
   logic gen_fail_close_fault, util_fail_close_warn, switch_unknown_warn;
   int tick = 0, cyc = 0, t0, n_mismatch = 0, total_checks = 0;
   ets_exp_t q[$];
   ets_exp_t e;
   wire [7:0] mon = {switch_unknown_warn, util_fail_close_warn, gen_fail_close_fault, cfg_input2,
      exercise_display, load_transfer_output, exercise_active, engine_start_cmd};
   ets_sequencer #(.TICKS_PER_SEC(TPS)) dut (.*);
   ets_switch_model sw (.*);
   always #2 aclk = ~aclk;
   // engine, calendar and hang guard
   always @(posedge aclk) begin
      engine_running <= engine_start_cmd;
      engine_ready_to_load <= engine_running;
      tick <= (tick == MINC - 1) ? 0 : tick + 1;
      if (tick == MINC - 1) cal_minute <= cal_minute + 6'h01;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready && q.size() > 0) begin
         e = q.pop_front();
         cmp(32'(s_axi_bresp), 32'(e.r));
      end
      if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
         e = q.pop_front();
         cmp(32'(s_axi_rresp), 32'(e.r));
         cmp(s_axi_rdata & e.m, e.d & e.m);
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [31:0] sch(input logic [5:0] m);
      return {8'h00, dur, 1'h0, iv, 1'h0, 3'h1, 4'h8, 2'h0, m};
   endfunction : sch
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("MISMATCH at %0t got %h exp %h", $time, g, x);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ad = 1'h0, wd = 1'h0;
      q.push_back('{32'h0, 32'h0, r});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         ad = ad | s_axi_awready;
         wd = wd | s_axi_wready;
         if (ad) s_axi_awvalid <= 1'h0;
         if (wd) s_axi_wvalid <= 1'h0;
      end while (!(ad && wd));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      q.push_back('{d, m, r});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic wait_for(input int b, input logic v, input int lim);
      int k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (mon[b] !== v && k < lim);
      cmp(32'(mon[b]), 32'(v));
   endtask : wait_for
   task print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ETS_SCHED_OFS, ETS_SCHED_RST, '1, ETS_RESP_OKAY);
      rd(ETS_TDLY_OFS, ETS_TDLY_RST, '1, ETS_RESP_OKAY);
      rd(ETS_SUPV_OFS, ETS_SUPV_RST, '1, ETS_RESP_OKAY);
      rd(8'h1C, 32'h0, '1, ETS_RESP_SLVERR);
      dur = 4'h5 + 4'(xs() % 11);
      for (int i = 0; i < 5; i++) begin
         iv = 3'(i);
         wr(ETS_SCHED_OFS, sch(6'h00), ETS_RESP_OKAY);
         rd(ETS_SCHED_OFS, sch(6'h00), '1, ETS_RESP_OKAY);
      end
      iv = 3'h0;
      st = 8'h01 + 8'(xs() % 3);
      sp = 8'h01 + 8'(xs() % 3);
      rt = 8'h01 + 8'(xs() % 3);
      tx = 8'h01 + 8'(xs() % 3);
      wr(ETS_TDLY_OFS, {st, sp, rt, tx}, ETS_RESP_OKAY);
      wr(ETS_SUPV_OFS, 32'h0002_0002, ETS_RESP_OKAY);
      wr(ETS_CTRL_OFS, 32'h1F, ETS_RESP_OKAY);
      wr(ETS_SCHED_OFS, sch(cal_minute + 6'h01), ETS_RESP_OKAY);
      repeat (2 * MINC) @(negedge aclk);
      cmp(32'(exercise_active), 32'h0);
      @(posedge aclk);
      clock_not_set_fault <= 1'h0;
      wr(ETS_SCHED_OFS, sch(cal_minute + 6'h01), ETS_RESP_OKAY);
      wait_for(1, 1'h1, MINC + 40);
      t0 = cyc;
      wr(ETS_SCHED_OFS, sch(6'h00), ETS_RESP_SLVERR);
      wr(ETS_CLOCK_OFS, 32'h0, ETS_RESP_SLVERR);
      wr(ETS_CTRL_OFS, 32'h1F, ETS_RESP_OKAY);
      rd(ETS_STAT_OFS, 32'h11, 32'h11, ETS_RESP_OKAY);
      cmp(32'({engine_start_cmd, rated_no_load, sleep_allowed}), 32'h6);
      wait_for(3, 1'h1, 3 * TPS + 10);
      wait_for(1, 1'h0, (int'(dur) + 1) * MINC);
      cmp(32'(cyc - t0 > int'(dur) * MINC - 40 && cyc - t0 < int'(dur) * MINC + 40), 32'h1);
      wait_for(0, 1'h0, 20);
      wr(ETS_CLR_OFS, 32'h1, ETS_RESP_OKAY);
      rd(ETS_STAT_OFS, 32'h0, 32'h10, ETS_RESP_OKAY);
      wr(ETS_SCHED_OFS, sch(cal_minute + 6'h01), ETS_RESP_OKAY);
      wait_for(1, 1'h1, MINC + 40);
      @(posedge aclk);
      volts <= 8'h40;
      wait_for(1, 1'h0, 20);
      cmp(32'(engine_start_cmd), 32'h1);
      t0 = cyc;
      wait_for(2, 1'h1, (int'(st) + int'(tx) + 4) * TPS);
      cmp(32'(cyc - t0 >= (int'(tx) - 1) * TPS && cfg_inputs_locked), 32'h1);
      wait_for(4, 1'h1, 20);
      repeat (3 * TPS) @(negedge aclk);
      cmp(32'(gen_fail_close_fault), 32'h0);
      @(posedge aclk);
      mode <= 2'h1;
      volts <= 8'hC8;
      t0 = cyc;
      wait_for(2, 1'h0, (int'(rt) + 3) * TPS);
      cmp(32'(cyc - t0 >= (int'(rt) - 1) * TPS), 32'h1);
      wait_for(6, 1'h1, 4 * TPS);
      cmp(32'(engine_start_cmd), 32'h1);
      @(posedge aclk);
      mode <= 2'h0;
      t0 = cyc;
      wait_for(0, 1'h0, (int'(sp) + 3) * TPS + 20);
      cmp(32'(cyc - t0 >= (int'(sp) - 1) * TPS), 32'h1);
      @(posedge aclk);
      mode <= 2'h2;
      wait_for(7, 1'h1, 20);
      @(posedge aclk);
      mode <= 2'h1;
      volts <= 8'h40;
      wait_for(5, 1'h1, (int'(st) + int'(tx) + 6) * TPS);
      print_verdict();
   end
endmodule : test_exercise_and_transfer_sequencer
bind ets_sequencer ets_sequencer_chk chk_i (.*);
